// *** dmx_map.vh ***
`ifndef DMX_MAP_VH
`define DMX_MAP_VH
// operation codes presented by the instruction decoder
`define DMX_OP_NONE      3'h0
`define DMX_OP_IND_LOAD  3'h1
`define DMX_OP_IND_REL   3'h2
`define DMX_OP_BANK_LIT  3'h3
`define DMX_OP_PAGE_LIT  3'h4
`define DMX_OP_ACC_LIT   3'h5
`define DMX_OP_ACC_STORE 3'h6
// pointer update codes
`define DMX_UPD_PRE_INC  2'h0
`define DMX_UPD_PRE_DEC  2'h1
`define DMX_UPD_POST_INC 2'h2
`define DMX_UPD_POST_DEC 2'h3
// field widths
`define DMX_PTR_W   16
`define DMX_BANK_W  5
`define DMX_PAGE_W  7
`define DMX_DATA_W  8
`define DMX_OFS_W   6
`define DMX_FADDR_W 7
// reset values
`define DMX_RST_PTR  16'h0000
`define DMX_RST_BANK 5'h00
`define DMX_RST_PAGE 7'h00
`define DMX_RST_ACC  8'h00
// cycles an indirect load waits for the data memory before done
`define DMX_LOAD_CYCLES 1
`endif

// *** dmx_addr_calc.v ***
`timescale 1ns/1ps
`include "dmx_map.vh"
// effective address and pointer write-back for one indirect access
module dmx_addr_calc #(
   parameter PTR_W = `DMX_PTR_W,
   parameter OFS_W = `DMX_OFS_W
) (
   input  wire [PTR_W-1:0] ptr,
   input  wire [1:0]       upd_code,
   input  wire             relative,
   input  wire [OFS_W-1:0] offset,
   output reg  [PTR_W-1:0] eff_addr,
   output reg  [PTR_W-1:0] ptr_next
);
   wire [PTR_W-1:0] ptr_inc;
   wire [PTR_W-1:0] ptr_dec;
   wire [PTR_W-1:0] ofs_ext;

   // 16-bit adders drop the carry so the pointer wraps
   assign ptr_inc = ptr + {{(PTR_W-1){1'b0}}, 1'b1}; // RQ6
   assign ptr_dec = ptr - {{(PTR_W-1){1'b0}}, 1'b1}; // RQ6
   assign ofs_ext = {{(PTR_W-OFS_W){offset[OFS_W-1]}}, offset}; // RQ4

   // pick address and write-back value by mode
   always @* begin
      eff_addr = ptr;
      ptr_next = ptr;
      if (relative) begin
         eff_addr = ptr + ofs_ext; // RQ3
         ptr_next = ptr;           // RQ4
      end else begin
         case (upd_code) // RQ2
            `DMX_UPD_PRE_INC: begin
               eff_addr = ptr_inc; // RQ3
               ptr_next = ptr_inc;
            end
            `DMX_UPD_PRE_DEC: begin
               eff_addr = ptr_dec; // RQ3
               ptr_next = ptr_dec;
            end
            `DMX_UPD_POST_INC: begin
               eff_addr = ptr;     // RQ3
               ptr_next = ptr_inc;
            end
            default: begin
               eff_addr = ptr;     // RQ3
               ptr_next = ptr_dec;
            end
         endcase
      end
   end
endmodule // dmx_addr_calc

// *** dmx_exec.v ***
// Overview of operation
// (RQ1) indirect load reads pointed data into accumulator, sets zero flag
// (RQ2) update code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// (RQ3) pre modes address pointer plus/minus one; post use pointer; relative adds
// (RQ4) relative offset is signed -32..31; pointer keeps its value
// (RQ5) indirect access port has no storage; it maps to pointed location
// (RQ6) pointers are 16 bits and wrap modulo 65536
// (RQ7) bank literal loads 5-bit value into bank select, flags untouched
// (RQ8) page literal loads 7-bit value into upper latch, flags untouched
// (RQ9) accumulator literal loads 8-bit value, no flags, one cycle
// (RQ10) store copies accumulator to 7-bit file address, no flags, one cycle
// (RQ11) one-bit select chooses which pointer is used and updated
`timescale 1ns/1ps
`include "dmx_map.vh"
module dmx_exec #(
   parameter PTR_W   = `DMX_PTR_W,
   parameter DATA_W  = `DMX_DATA_W
) (
   input  wire                     mclk,
   input  wire                     rst_n,
   input  wire                     op_valid,
   input  wire [2:0]               op_code,
   input  wire                     ptr_sel,
   input  wire [1:0]               pointer_update_code,
   input  wire [`DMX_OFS_W-1:0]    rel_offset,
   input  wire [DATA_W-1:0]        literal,
   input  wire [`DMX_FADDR_W-1:0]  file_addr,
   input  wire [DATA_W-1:0]        mem_rdata,
   output reg  [PTR_W-1:0]         mem_addr,
   output reg                      mem_rd,
   output reg  [`DMX_FADDR_W-1:0]  file_waddr,
   output reg  [DATA_W-1:0]        file_wdata,
   output reg                      file_we,
   output wire                     busy,
   output reg                      done,
   output reg  [DATA_W-1:0]        accumulator,
   output reg                      zero_flag,
   output reg  [`DMX_BANK_W-1:0]   bank_select_register,
   output reg  [`DMX_PAGE_W-1:0]   program_counter_upper_latch,
   output wire [PTR_W-1:0]         pointer_register0,
   output wire [PTR_W-1:0]         pointer_register1
);
   localparam ST_IDLE = 1'b0;
   localparam ST_READ = 1'b1;

   reg              state_q;
   reg              state_d;
   reg [PTR_W-1:0]  ptr_q [0:1];
   reg [PTR_W-1:0]  ptr_d0;
   reg [PTR_W-1:0]  ptr_d1;
   wire [PTR_W-1:0] sel_ptr;
   wire [PTR_W-1:0] eff_addr;
   wire [PTR_W-1:0] ptr_next;
   wire             is_rel;
   wire             is_ind;

   // true for both indirect load forms
   function is_indirect;
      input [2:0] code;
      begin
         is_indirect = (code == `DMX_OP_IND_LOAD) ||
                       (code == `DMX_OP_IND_REL);
      end
   endfunction

   assign is_ind  = op_valid && (state_q == ST_IDLE) && is_indirect(op_code);
   assign is_rel  = (op_code == `DMX_OP_IND_REL);
   assign sel_ptr = ptr_q[ptr_sel]; // RQ11
   assign busy    = (state_q == ST_READ);
   assign pointer_register0 = ptr_q[0];
   assign pointer_register1 = ptr_q[1];

   dmx_addr_calc #(
      .PTR_W (PTR_W),
      .OFS_W (`DMX_OFS_W)
   ) u_addr (
      .ptr      (sel_ptr),
      .upd_code (pointer_update_code),
      .relative (is_rel),
      .offset   (rel_offset),
      .eff_addr (eff_addr),
      .ptr_next (ptr_next)
   );

   // next pointer values; only the selected pointer moves
   always @* begin
      ptr_d0 = ptr_q[0];
      ptr_d1 = ptr_q[1];
      if (is_ind) begin
         if (ptr_sel)
            ptr_d1 = ptr_next; // RQ11
         else
            ptr_d0 = ptr_next; // RQ11
      end
   end

   // state: indirect load waits one cycle for the data memory
   always @* begin
      case (state_q)
         ST_IDLE: state_d = is_ind ? ST_READ : ST_IDLE;
         ST_READ: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // pointer storage and sequencing
   always @(posedge mclk) begin
      if (!rst_n) begin
         state_q  <= ST_IDLE;
         ptr_q[0] <= `DMX_RST_PTR;
         ptr_q[1] <= `DMX_RST_PTR;
      end else begin
         state_q  <= state_d;
         ptr_q[0] <= ptr_d0; // RQ6
         ptr_q[1] <= ptr_d1; // RQ6
      end
   end

   // memory strobes: address is the pointed location, not a stored port
   always @(posedge mclk) begin
      if (!rst_n) begin
         mem_addr   <= `DMX_RST_PTR;
         mem_rd     <= 1'b0;
         file_waddr <= {`DMX_FADDR_W{1'b0}};
         file_wdata <= `DMX_RST_ACC;
         file_we    <= 1'b0;
      end else begin
         mem_rd  <= is_ind;
         file_we <= 1'b0;
         if (is_ind)
            mem_addr <= eff_addr; // RQ5
         if (op_valid && (state_q == ST_IDLE) &&
             (op_code == `DMX_OP_ACC_STORE)) begin
            file_waddr <= file_addr;   // RQ10
            file_wdata <= accumulator; // RQ10
            file_we    <= 1'b1;
         end
      end
   end

   // architectural registers; literals never touch the zero flag
   always @(posedge mclk) begin
      if (!rst_n) begin
         accumulator                 <= `DMX_RST_ACC;
         zero_flag                   <= 1'b0;
         bank_select_register        <= `DMX_RST_BANK;
         program_counter_upper_latch <= `DMX_RST_PAGE;
         done                        <= 1'b0;
      end else begin
         done <= 1'b0;
         if (state_q == ST_READ) begin
            accumulator <= mem_rdata;                  // RQ1
            zero_flag   <= (mem_rdata == {DATA_W{1'b0}}); // RQ1
            done        <= 1'b1;
         end else if (op_valid) begin
            case (op_code)
               `DMX_OP_BANK_LIT: begin
                  bank_select_register <= literal[`DMX_BANK_W-1:0]; // RQ7
                  done <= 1'b1;
               end
               `DMX_OP_PAGE_LIT: begin
                  program_counter_upper_latch <=
                     literal[`DMX_PAGE_W-1:0]; // RQ8
                  done <= 1'b1;
               end
               `DMX_OP_ACC_LIT: begin
                  accumulator <= literal; // RQ9
                  done        <= 1'b1;
               end
               `DMX_OP_ACC_STORE: begin
                  done <= 1'b1; // RQ10
               end
               default: begin
                  done <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule // dmx_exec

// *** dmx_exec_monitor.sv ***
`timescale 1ns/1ps
module dmx_exec_monitor (
   input wire        mclk,
   input wire        rst_n,
   input wire        op_valid,
   input wire [2:0]  op_code,
   input wire        ptr_sel,
   input wire [1:0]  pointer_update_code,
   input wire [5:0]  rel_offset,
   input wire [7:0]  literal,
   input wire [6:0]  file_addr,
   input wire [7:0]  mem_rdata,
   input wire [15:0] mem_addr,
   input wire        mem_rd,
   input wire [6:0]  file_waddr,
   input wire [7:0]  file_wdata,
   input wire        file_we,
   input wire        busy,
   input wire        done,
   input wire [7:0]  accumulator,
   input wire        zero_flag,
   input wire [4:0]  bank_select_register,
   input wire [6:0]  program_counter_upper_latch,
   input wire [15:0] pointer_register0,
   input wire [15:0] pointer_register1
);
   // accepted request and the addresses it should lead to
   wire        take = op_valid && !busy;
   wire [15:0] rel0 = pointer_register0 + {{10{rel_offset[5]}}, rel_offset};
   wire [15:0] inc0 = pointer_register0 + 16'h0001;
   wire [15:0] dec1 = pointer_register1 - 16'h0001;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_BANK: assert property (take && op_code == 3'h3 |=> done &&
      bank_select_register == $past(literal[4:0])) else $error("bank load");
   AST_PAGE: assert property (take && op_code == 3'h4 |=>
      $stable(zero_flag) &&
      program_counter_upper_latch == $past(literal[6:0])) else $error("page");
   AST_ACC: assert property (take && op_code == 3'h5 |=> done &&
      accumulator == $past(literal) && $stable(zero_flag)) else $error("acc");
   AST_STORE: assert property (take && op_code == 3'h6 |=> file_we &&
      file_waddr == $past(file_addr) && file_wdata == $past(accumulator))
      else $error("store");
   AST_LOAD: assert property (mem_rd |=> done &&
      accumulator == $past(mem_rdata) && zero_flag == ($past(mem_rdata) == 8'h00))
      else $error("load");
   AST_PRE_INC: assert property (take && op_code == 3'h1 && !ptr_sel &&
      pointer_update_code == 2'h0 |=> mem_rd && mem_addr == $past(inc0) &&
      pointer_register0 == $past(inc0)) else $error("pre increment");
   AST_POST_DEC: assert property (take && op_code == 3'h1 && ptr_sel &&
      pointer_update_code == 2'h3 |=> mem_addr == $past(pointer_register1) &&
      pointer_register1 == $past(dec1)) else $error("post decrement");
   AST_REL: assert property (take && op_code == 3'h2 && !ptr_sel |=> busy &&
      mem_addr == $past(rel0) && $stable(pointer_register0)) else $error("rel");
endmodule // dmx_exec_monitor
bind dmx_exec dmx_exec_monitor i_dmx_exec_monitor (.*);

// *** dmx_mem_model.sv ***
`timescale 1ns/1ps
// data memory stand-in, content is a hash of the address
module dmx_mem_model (
   input  wire        mclk,
   input  wire [15:0] mem_addr,
   input  wire        mem_rd,
   output wire [7:0]  mem_rdata
);
   reg  [7:0] last_q;
   wire [7:0] word = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h05;
   // off a read the bus shows the inverse, so a late sample is caught
   assign mem_rdata = mem_rd ? word : ~last_q;
   always @(posedge mclk) begin
      if (mem_rd) last_q <= word;
   end
endmodule // dmx_mem_model

// *** dmx_exec_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin checked = checked + 1; if ((a) !== (e)) begin \
   miscompares = miscompares + 1; $display("[FAIL] %0t %h %h", $time, a, e); end end
module dmx_exec_tb;
   reg         mclk, rst_n, op_valid, ptr_sel;
   reg  [2:0]  op_code;
   reg  [1:0]  pointer_update_code;
   reg  [5:0]  rel_offset;
   reg  [7:0]  literal, acc;
   reg  [6:0]  file_addr, pg;
   reg  [15:0] ptr [0:1];
   reg  [15:0] ea, p;
   reg  [4:0]  bnk;
   reg         zf;
   integer     seed, i, n, miscompares, checked;
   wire [7:0]  mem_rdata, file_wdata, accumulator;
   wire [15:0] mem_addr, pointer_register0, pointer_register1;
   wire [6:0]  file_waddr, program_counter_upper_latch;
   wire [4:0]  bank_select_register;
   wire        mem_rd, file_we, busy, done, zero_flag;
   dmx_exec i_dmx_exec (.*);
   dmx_mem_model i_dmx_mem_model (.*);
   function [7:0] mem_word(input [15:0] a);
      mem_word = a[7:0] ^ a[15:8] ^ 8'h05;
   endfunction
   task complete_run;
      begin
         if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // one request, then a bounded wait for done
   task run_op(input [2:0] c, input s, input [1:0] u, input [5:0] o);
      begin
         @(posedge mclk);
         op_valid <= 1'b1;
         op_code <= c;
         ptr_sel <= s;
         pointer_update_code <= u;
         rel_offset <= o;
         literal <= $random(seed);
         file_addr <= $random(seed);
         @(posedge mclk);
         op_valid <= 1'b0;
         n = 0;
         do begin @(negedge mclk); n = n + 1; end while (done !== 1'b1 && n < 4);
         if (done !== 1'b1) begin miscompares = miscompares + 1; complete_run; end
         p = ptr[s];
         ea = c == 3'h2 ? p + {{10{o[5]}}, o} : u[1] ? p :
              u[0] ? p - 16'h0001 : p + 16'h0001;
         if (c == 3'h1) ptr[s] = u[0] ? p - 16'h0001 : p + 16'h0001;
         if (c == 3'h1 || c == 3'h2) begin
            acc = mem_word(ea);
            zf = acc == 8'h00;
            `CHK(mem_addr, ea)
         end
         if (c == 3'h3) bnk = literal[4:0];
         if (c == 3'h4) pg = literal[6:0];
         if (c == 3'h6) begin
            `CHK({file_we, file_waddr}, {1'b1, file_addr})
            `CHK(file_wdata, acc)
         end
         if (c == 3'h5) acc = literal;
         `CHK(accumulator, acc)
         `CHK(zero_flag, zf)
         `CHK(bank_select_register, bnk)
         `CHK(program_counter_upper_latch, pg)
         `CHK(pointer_register0, ptr[0])
         `CHK(pointer_register1, ptr[1])
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // reset, wrap and offset corners, then random traffic
   initial begin
      {rst_n, op_valid, ptr_sel, op_code, pointer_update_code} = 8'h00;
      {rel_offset, literal, file_addr} = 21'h000000;
      {acc, pg, bnk, zf, ptr[0], ptr[1]} = 53'h0;
      seed = 91969;
      miscompares = 0;
      checked = 0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      run_op(3'h1, 1'b0, 2'h1, 6'h00);
      run_op(3'h1, 1'b1, 2'h3, 6'h00);
      run_op(3'h2, 1'b1, 2'h0, 6'h20);
      run_op(3'h2, 1'b0, 2'h0, 6'h1F);
      // refused codes 7 and 0 must finish nothing
      @(posedge mclk);
      op_valid <= 1'b1;
      op_code <= 3'h7;
      @(posedge mclk);
      op_code <= 3'h0;
      @(negedge mclk);
      `CHK({done, mem_rd, file_we}, 3'b000)
      @(posedge mclk);
      op_valid <= 1'b0;
      @(negedge mclk);
      `CHK({done, mem_rd, file_we, accumulator}, {3'b000, acc})
      // a literal offered while the read is in flight is ignored
      @(posedge mclk);
      op_valid <= 1'b1;
      op_code <= 3'h1;
      ptr_sel <= 1'b0;
      pointer_update_code <= 2'h2;
      @(posedge mclk);
      op_code <= 3'h5;
      literal <= 8'hA5;
      @(posedge mclk);
      op_valid <= 1'b0;
      @(negedge mclk);
      acc = mem_word(ptr[0]);
      zf = acc == 8'h00;
      ptr[0] = ptr[0] + 16'h0001;
      `CHK({done, accumulator, zero_flag}, {1'b1, acc, zf})
      `CHK(pointer_register0, ptr[0])
      // reset again in mid-run; everything returns to zero
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      `CHK({accumulator, zero_flag, pointer_register0}, 25'h0)
      `CHK(pointer_register1, 16'h0000)
      `CHK({bank_select_register, program_counter_upper_latch}, 12'h000)
      {acc, pg, bnk, zf, ptr[0], ptr[1]} = 53'h0;
      for (i = 0; i < 400; i = i + 1)
         run_op(3'h1 + {$random(seed)} % 6, $random(seed), $random(seed),
                $random(seed));
      complete_run;
   end
endmodule // dmx_exec_tb
